// ### design/asr_map.vh
// Register offsets, field positions, reset values and sample timing of the serial receiver.
`ifndef ASR_MAP_VH
`define ASR_MAP_VH

// ----------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------
`define ASR_OFF_CTRL1   3'h0
`define ASR_OFF_CTRL2   3'h1
`define ASR_OFF_CTRL3   3'h2
`define ASR_OFF_STAT1   3'h3
`define ASR_OFF_DATA    3'h4

// ----------------------------------------------------------------------
// First control register fields.
// ----------------------------------------------------------------------
`define ASR_C1_LOOP     7
`define ASR_C1_EN       6
`define ASR_C1_TRANSMIT_POLARITY_INVERT    5
`define ASR_C1_CHAR9    4
`define ASR_C1_WAKE     3
`define ASR_C1_QTYPE    2
`define ASR_C1_PEN      1
`define ASR_C1_PODD     0

// ----------------------------------------------------------------------
// Second and third control register fields.
// ----------------------------------------------------------------------
`define ASR_C2_TXIE     7
`define ASR_C2_TCIE     6
`define ASR_C2_RXIE     5
`define ASR_C2_QIE      4
`define ASR_C2_TE       3
`define ASR_C2_RE       2
`define ASR_C2_RWU      1
`define ASR_C2_SBK      0
`define ASR_C3_R8       7
`define ASR_C3_T8       6

// ----------------------------------------------------------------------
// Status bits; the low four match the error enables of the third register.
// ----------------------------------------------------------------------
`define ASR_S1_TXE      7
`define ASR_S1_TXD      6
`define ASR_S1_FULL     5
`define ASR_S1_QUIET    4
`define ASR_S1_OVR      3
`define ASR_S1_NOISE    2
`define ASR_S1_FRAME    1
`define ASR_S1_PAR      0

// ----------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------
`define ASR_RST_CTRL    8'h00
`define ASR_RST_DATA    9'h000

// ----------------------------------------------------------------------
// Sample points in 16x ticks and frame lengths in bits.
// ----------------------------------------------------------------------
`define ASR_RT_S3       5'h03
`define ASR_RT_S5       5'h05
`define ASR_RT_S7       5'h07
`define ASR_RT_S8       5'h08
`define ASR_RT_S9       5'h09
`define ASR_RT_S10      5'h0A
`define ASR_RT_END      5'h10
`define ASR_FRAME_8     8'h0A
`define ASR_FRAME_9     8'h0B

`endif

// ### design/asr_rx_ctrl.v
// Receiver control, status flags and pin ownership of an asynchronous serial port.
`timescale 1ns/1ps
`include "asr_map.vh"

module asr_rx_ctrl (
  input  wire       i_clk_sys,
  input  wire       i_rst_n,
  input  wire       i_ce,
  input  wire       i_rt_tick,
  input  wire [2:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output wire [7:0] o_rdata,
  input  wire       i_rx_pin,
  input  wire       i_tx_bit,
  input  wire       i_tx_empty,
  input  wire       i_tx_done,
  input  wire [1:0] i_port_out,
  input  wire [1:0] i_port_dir,
  input  wire       i_wait_mode,
  input  wire       i_dbg_break,
  input  wire       i_break_clear_en,
  output wire       o_tx_pin_o,
  output wire       o_tx_pin_oe,
  output wire       o_rx_pin_o,
  output wire       o_rx_pin_oe,
  output wire [7:0] o_ctrl_one,
  output wire       o_tx_enable,
  output wire       o_send_break,
  output wire       o_tx_bit8,
  output wire       o_irq_rx,
  output wire       o_irq_tx,
  output wire       o_irq_err,
  output wire       o_wake_req
);

  // ----------------------------------------------------------------------
  // Receiver states.
  // ----------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_START = 2'b01;
  localparam [1:0] ST_DATA  = 2'b10;
  localparam [1:0] ST_STOP  = 2'b11;

  reg  [7:0] ctrl1_ff;
  reg  [7:0] ctrl2_ff;
  reg  [5:0] ctrl3_ff;
  reg  [5:0] flag_ff;
  reg  [5:0] arm_ff;
  reg        txe_ff;
  reg        txd_ff;
  reg  [8:0] data_ff;
  reg  [7:0] rdata_ff;
  reg  [1:0] rx_sync_ff;
  reg  [1:0] st_ff;
  reg  [4:0] rt_ff;
  reg  [2:0] hist_ff;
  reg  [1:0] smp_ff;
  reg  [3:0] bit_ff;
  reg  [8:0] shf_ff;
  reg        nz_ff;
  reg  [7:0] qcnt_ff;
  reg        qarm_ff;
  reg        irq_rx_ff;
  reg        irq_tx_ff;
  reg        irq_err_ff;
  reg        wake_ff;
  reg        tx_o_ff;
  reg        tx_oe_ff;
  reg        rx_o_ff;
  reg        rx_oe_ff;

  // Majority of three samples.
  function maj3;
    input a;
    input b;
    input c;
    begin
      maj3 = (a & b) | (a & c) | (b & c);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Control decode and receive input selection.
  // ----------------------------------------------------------------------
  wire       en      = ctrl1_ff[`ASR_C1_EN];
  wire       char9   = ctrl1_ff[`ASR_C1_CHAR9];
  wire       wake_am = ctrl1_ff[`ASR_C1_WAKE];
  wire       receiver_standby_bit     = ctrl2_ff[`ASR_C2_RWU];
  wire       loop_on = ctrl1_ff[`ASR_C1_LOOP] & ctrl2_ff[`ASR_C2_TE] & ctrl2_ff[`ASR_C2_RE];
  wire       rxd     = loop_on ? i_tx_bit : rx_sync_ff[1];
  wire       rx_run  = en & ctrl2_ff[`ASR_C2_RE];
  wire       tick    = i_ce & i_rt_tick & rx_run;
  wire       acc     = i_ce & ~i_wait_mode;
  wire       protect = i_dbg_break & ~i_break_clear_en;
  wire       wr_en   = acc & i_wr;
  wire       rd_en   = acc & i_rd;
  wire [3:0] nbits   = char9 ? 4'h9 : 4'h8;
  wire [7:0] qlimit  = char9 ? `ASR_FRAME_9 : `ASR_FRAME_8;

  // Sample taken at RT10 together with the two held ones.
  wire       bit_val = maj3(smp_ff[1], smp_ff[0], rxd);
  wire       bit_nz  = ~((smp_ff[1] == smp_ff[0]) & (smp_ff[0] == rxd));
  wire       at_s10  = tick & (rt_ff == `ASR_RT_S10);

  // Character completes at the third stop sample.
  wire       done_evt = at_s10 & (st_ff == ST_STOP);
  wire       frame_nz = nz_ff | bit_nz;
  wire [8:0] chr      = char9 ? shf_ff : {1'b0, shf_ff[8:1]};
  wire       msb      = char9 ? chr[8] : chr[7];
  wire       par_bad  = ctrl1_ff[`ASR_C1_PEN] & ((^chr) ^ ctrl1_ff[`ASR_C1_PODD]);
  wire       accept   = ~receiver_standby_bit | (wake_am & msb);

  // Quiet counting runs on the idle line, and through data bits only when counting
  // starts after the start bit.
  wire       qcount   = (st_ff == ST_IDLE) | (~ctrl1_ff[`ASR_C1_QTYPE] & (st_ff != ST_START));
  wire       quiet_evt = tick & qcount & rxd & qarm_ff & (qcnt_ff == {qlimit[3:0], 4'h0} - 8'h01);
  wire       idle_wake = quiet_evt & receiver_standby_bit & ~wake_am;

  // Flags cleared by the second step of the status-then-data sequence.
  wire       dat_rd   = rd_en & (i_addr == `ASR_OFF_DATA) & ~protect;
  wire       sts_rd   = rd_en & (i_addr == `ASR_OFF_STAT1) & ~protect;
  wire [5:0] clr_mask = dat_rd ? arm_ff : 6'h00;

  // ----------------------------------------------------------------------
  // Receive pin synchroniser.
  // ----------------------------------------------------------------------
  // Two flops keep the asynchronous line out of the sampling logic.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rx_sync_ff <= 2'b11;
    end else if (i_ce) begin
      rx_sync_ff <= {rx_sync_ff[0], i_rx_pin};
    end
  end

  // ----------------------------------------------------------------------
  // Bit recovery.
  // ----------------------------------------------------------------------
  // Start search, start verification, data and stop sampling on the 16x tick.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n || (i_ce && !rx_run)) begin
      st_ff   <= ST_IDLE;
      rt_ff   <= 5'h00;
      hist_ff <= 3'b000;
      smp_ff  <= 2'b00;
      bit_ff  <= 4'h0;
      shf_ff  <= 9'h000;
      nz_ff   <= 1'b0;
    end else if (tick) begin
      rt_ff <= rt_ff + 5'h01;
      if (rt_ff == `ASR_RT_S8 || rt_ff == `ASR_RT_S9 || rt_ff == `ASR_RT_S3 ||
          rt_ff == `ASR_RT_S5) begin
        smp_ff <= {smp_ff[0], rxd};
      end
      case (st_ff)
        ST_IDLE: begin
          hist_ff <= {hist_ff[1:0], rxd};
          if (hist_ff == 3'b111 && !rxd) begin
            st_ff <= ST_START;
            rt_ff <= 5'h01;
            nz_ff <= 1'b0;
          end
        end
        ST_START: begin
          if (rt_ff == `ASR_RT_S7) begin
            if (maj3(smp_ff[1], smp_ff[0], rxd)) begin
              st_ff   <= ST_IDLE; // False start: search again.
              hist_ff <= 3'b000;
            end else if (bit_nz) begin
              nz_ff <= 1'b1;
            end
          end
          if ((rt_ff == `ASR_RT_S8 || rt_ff == `ASR_RT_S9 || rt_ff == `ASR_RT_S10) && rxd) begin
            nz_ff <= 1'b1;
          end
          if (rt_ff == `ASR_RT_END) begin
            st_ff  <= ST_DATA;
            rt_ff  <= 5'h01;
            bit_ff <= 4'h0;
          end
        end
        ST_DATA: begin
          if (rt_ff == `ASR_RT_S10) begin
            shf_ff <= {bit_val, shf_ff[8:1]};
            if (bit_nz) begin
              nz_ff <= 1'b1;
            end
          end
          if (rt_ff == `ASR_RT_END) begin
            rt_ff  <= 5'h01;
            bit_ff <= bit_ff + 4'h1;
            if (bit_ff == nbits - 4'h1) begin
              st_ff <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (rt_ff == `ASR_RT_S10) begin
            st_ff   <= ST_IDLE;
            hist_ff <= {3{bit_val}};
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Quiet line counter.
  // ----------------------------------------------------------------------
  // Counts ticks of high line; one quiet event after reset and after each received traffic burst.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      qcnt_ff <= 8'h00;
      qarm_ff <= 1'b1;
    end else if (i_ce) begin
      if (tick) begin
        qcnt_ff <= (qcount && rxd && qcnt_ff != 8'hFF) ? qcnt_ff + 8'h01 : 8'h00;
      end
      if (done_evt || (tick && st_ff == ST_START)) begin
        qarm_ff <= 1'b1;
      end else if (quiet_evt) begin
        qarm_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------------
  // Software writes; hardware clears the standby bit on wake, a write of one wins.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctrl1_ff <= `ASR_RST_CTRL;
      ctrl2_ff <= `ASR_RST_CTRL;
      ctrl3_ff <= 6'h00;
    end else if (i_ce) begin
      if ((done_evt && receiver_standby_bit && wake_am && msb) || idle_wake) begin
        ctrl2_ff[`ASR_C2_RWU] <= 1'b0;
      end
      if (wr_en) begin
        case (i_addr)
          `ASR_OFF_CTRL1: ctrl1_ff <= i_wdata;
          `ASR_OFF_CTRL2: begin
            ctrl2_ff[7:4] <= i_wdata[7:4];
            ctrl2_ff[1:0] <= i_wdata[1:0];
            if (en) begin
              ctrl2_ff[3:2] <= i_wdata[3:2];
            end
          end
          `ASR_OFF_CTRL3: ctrl3_ff <= {i_wdata[`ASR_C3_T8], 1'b0, i_wdata[3:0]};
          default: ctrl3_ff <= ctrl3_ff;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receive flags, data buffer and clear sequence.
  // ----------------------------------------------------------------------
  // New events are merged after the clear so a set in the clearing cycle survives.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      flag_ff <= 6'h00;
      arm_ff  <= 6'h00;
      data_ff <= `ASR_RST_DATA;
    end else if (i_ce) begin
      if (sts_rd) begin
        arm_ff <= flag_ff;
      end else if (dat_rd) begin
        arm_ff <= 6'h00;
      end
      flag_ff <= (flag_ff & ~clr_mask)
               | {5'h00, 1'b0} ;
      if (done_evt && accept) begin
        if (flag_ff[`ASR_S1_FULL] && !clr_mask[`ASR_S1_FULL]) begin
          flag_ff <= (flag_ff & ~clr_mask) | 6'b00_1000;
        end else begin
          data_ff <= char9 ? chr : {chr[7], chr[7:0]};
          flag_ff <= (flag_ff & ~clr_mask)
                   | {1'b1, 2'b00, frame_nz, ~bit_val, par_bad};
        end
      end else if (done_evt) begin
        flag_ff <= flag_ff & ~clr_mask;
      end
      if (quiet_evt && !receiver_standby_bit) begin
        flag_ff[`ASR_S1_QUIET] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmit status follows the transmitter, forced set while disabled.
  // ----------------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      txe_ff <= 1'b1;
      txd_ff <= 1'b1;
    end else if (i_ce) begin
      txe_ff <= ~en | i_tx_empty;
      txd_ff <= ~en | i_tx_done;
    end
  end

  // ----------------------------------------------------------------------
  // Read data, requests and pins.
  // ----------------------------------------------------------------------
  // All outputs are registered; requests stay live in wait mode to end it.
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rdata_ff   <= 8'h00;
      irq_rx_ff  <= 1'b0;
      irq_tx_ff  <= 1'b0;
      irq_err_ff <= 1'b0;
      wake_ff    <= 1'b0;
      tx_o_ff    <= 1'b1;
      tx_oe_ff   <= 1'b0;
      rx_o_ff    <= 1'b0;
      rx_oe_ff   <= 1'b0;
    end else if (i_ce) begin
      rdata_ff <= 8'h00;
      if (rd_en) begin
        case (i_addr)
          `ASR_OFF_CTRL1: rdata_ff <= ctrl1_ff;
          `ASR_OFF_CTRL2: rdata_ff <= ctrl2_ff;
          `ASR_OFF_CTRL3: rdata_ff <= {data_ff[8], ctrl3_ff[5], 2'b00, ctrl3_ff[3:0]};
          `ASR_OFF_STAT1: rdata_ff <= {txe_ff, txd_ff, flag_ff};
          `ASR_OFF_DATA:  rdata_ff <= data_ff[7:0];
          default:        rdata_ff <= 8'h00;
        endcase
      end
      irq_rx_ff  <= ~receiver_standby_bit & ((flag_ff[5] & ctrl2_ff[`ASR_C2_RXIE]) |
                            (flag_ff[4] & ctrl2_ff[`ASR_C2_QIE]));
      irq_err_ff <= |(flag_ff[3:0] & ctrl3_ff[3:0]);
      irq_tx_ff  <= en & ((txe_ff & ctrl2_ff[`ASR_C2_TXIE]) |
                          (txd_ff & ctrl2_ff[`ASR_C2_TCIE]));
      wake_ff    <= i_wait_mode & (irq_rx_ff | irq_tx_ff | irq_err_ff);
      tx_o_ff    <= en ? (ctrl1_ff[`ASR_C1_TRANSMIT_POLARITY_INVERT] ^ i_tx_bit) : i_port_out[1];
      tx_oe_ff   <= en | i_port_dir[1];
      rx_o_ff    <= i_port_out[0];
      rx_oe_ff   <= ~en & i_port_dir[0];
    end
  end

  assign o_rdata      = rdata_ff;
  assign o_tx_pin_o   = tx_o_ff;
  assign o_tx_pin_oe  = tx_oe_ff;
  assign o_rx_pin_o   = rx_o_ff;
  assign o_rx_pin_oe  = rx_oe_ff;
  assign o_ctrl_one   = ctrl1_ff;
  assign o_tx_enable  = ctrl2_ff[`ASR_C2_TE];
  assign o_send_break = ctrl2_ff[`ASR_C2_SBK];
  assign o_tx_bit8    = ctrl3_ff[5];
  assign o_irq_rx     = irq_rx_ff;
  assign o_irq_tx     = irq_tx_ff;
  assign o_irq_err    = irq_err_ff;
  assign o_wake_req   = wake_ff;

endmodule // asr_rx_ctrl

// ### dv/asr_far_end.sv
// Behavioural remote serial transmitter that drives frames onto the receive pin.
`timescale 1ns/1ps

module asr_far_end (
  input  wire        i_clk_sys,
  input  wire        i_rt_tick,
  input  wire        i_go,
  input  wire [10:0] i_frame,
  input  wire [3:0]  i_nbits,
  output wire        o_line,
  output wire        o_busy
);
  reg [10:0] shift_ff;
  reg [3:0]  left_ff;
  reg [3:0]  tick_ff;
  reg        line_ff = 1'b1;
  reg        busy_ff = 1'b0;

  // ----------------------------------------------------------------------
  // Frame shifter.
  // ----------------------------------------------------------------------
  // Each bit stands for 16 sample ticks, least significant first; the line idles high.
  always @(posedge i_clk_sys) begin
    if (i_go) begin
      shift_ff <= i_frame;
      left_ff  <= i_nbits;
      tick_ff  <= 4'h0;
      busy_ff  <= 1'b1;
      line_ff  <= i_frame[0];
    end else if (busy_ff && i_rt_tick) begin
      tick_ff <= tick_ff + 4'h1;
      if (tick_ff == 4'hF) begin
        if (left_ff == 4'h1) begin
          busy_ff <= 1'b0;
          line_ff <= 1'b1;
        end else begin
          line_ff  <= shift_ff[1];
          shift_ff <= shift_ff >> 1;
          left_ff  <= left_ff - 4'h1;
        end
      end
    end
  end

  assign o_line = line_ff;
  assign o_busy = busy_ff;
endmodule // asr_far_end

// ### dv/asr_rx_ctrl_sva.sv
// Concurrent checks on the bus and pins of the serial receiver control block.
`timescale 1ns/1ps

module asr_rx_ctrl_sva (
  input wire       i_clk_sys,
  input wire       i_rst_n,
  input wire       i_rd,
  input wire       i_wait_mode,
  input wire       i_tx_bit,
  input wire [7:0] o_rdata,
  input wire       o_tx_pin_o,
  input wire       o_tx_pin_oe,
  input wire       o_rx_pin_oe,
  input wire [7:0] o_ctrl_one,
  input wire       o_irq_rx,
  input wire       o_irq_tx,
  input wire       o_irq_err,
  input wire       o_wake_req
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // ----------------------------------------------------------------------
  // Properties.
  // ----------------------------------------------------------------------
  chk_ctrl_reset: assert property ($rose(i_rst_n) |-> o_ctrl_one == 8'h00)
    else $error("first control register not cleared by reset");
  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside the read answer cycle");
  chk_wait_read: assert property ($past(i_rd && i_wait_mode) |-> o_rdata == 8'h00)
    else $error("register read answered in wait mode");
  chk_wake_req: assert property ((i_wait_mode && o_irq_rx) [*3] |-> o_wake_req)
    else $error("pending request did not wake");
  chk_tx_owned: assert property (o_ctrl_one[6] [*2] |-> o_tx_pin_oe)
    else $error("transmit pin not driven while enabled");
  chk_rx_owned: assert property (o_ctrl_one[6] [*2] |-> !o_rx_pin_oe)
    else $error("receive pin driven while enabled");
  chk_tx_invert: assert property (
    (o_ctrl_one[6] && $stable(o_ctrl_one) && $stable(i_tx_bit)) [*2]
    |-> o_tx_pin_o == (i_tx_bit ^ o_ctrl_one[5]))
    else $error("transmit pin level wrong for polarity");
  chk_tx_irq_off: assert property (!o_ctrl_one[6] [*2] |-> !o_irq_tx)
    else $error("transmit request while port disabled");

  // Main scenarios reached.
  cov_rx_req: cover property ($rose(o_irq_rx));
  cov_err_req: cover property ($rose(o_irq_err));
  cov_wake: cover property ($rose(o_wake_req));
  cov_disable: cover property ($fell(o_ctrl_one[6]));
endmodule // asr_rx_ctrl_sva

bind asr_rx_ctrl asr_rx_ctrl_sva u_sva (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_rd(i_rd), .i_wait_mode(i_wait_mode),
  .i_tx_bit(i_tx_bit), .o_rdata(o_rdata), .o_tx_pin_o(o_tx_pin_o), .o_tx_pin_oe(o_tx_pin_oe),
  .o_rx_pin_oe(o_rx_pin_oe), .o_ctrl_one(o_ctrl_one), .o_irq_rx(o_irq_rx),
  .o_irq_tx(o_irq_tx), .o_irq_err(o_irq_err), .o_wake_req(o_wake_req));

// ### dv/tb.sv
// Self-checking testbench of the serial receiver control block.
`timescale 1ns/1ps
`include "asr_map.vh"

module tb;
  logic        clk    = 1'b0;
  logic        rst_n  = 1'b0;
  logic        rt     = 1'b0;
  logic [2:0]  addr   = 3'h0;
  logic [7:0]  wdata  = 8'h00;
  logic        wr_s   = 1'b0;
  logic        rd_s   = 1'b0;
  logic        wait_m = 1'b0;
  logic        dbg    = 1'b0;
  logic        tx_bit = 1'b1;
  logic [1:0]  pdir   = 2'h1;
  logic        go     = 1'b0;
  logic [10:0] frame  = 11'h7FF;
  logic [3:0]  nb     = 4'hA;
  logic        lb     = 1'b0;
  logic        bce    = 1'b0;
  wire         line, busy, tx_o, tx_oe, rx_oe, irq_rx, irq_tx, irq_err, wake;
  wire         rx_o, te_o, sbk_o, t8_o;
  wire [7:0]   rdata, c1;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          cyc        = 0;

  asr_rx_ctrl u_dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_rt_tick(rt), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .i_rx_pin(lb ? 1'b1 : line), .i_tx_bit(lb ? line : tx_bit), .i_tx_empty(1'b1),
    .i_tx_done(1'b1), .i_port_out(2'h1),
    .i_port_dir(pdir), .i_wait_mode(wait_m), .i_dbg_break(dbg), .i_break_clear_en(bce),
    .o_tx_pin_o(tx_o), .o_tx_pin_oe(tx_oe), .o_rx_pin_o(rx_o), .o_rx_pin_oe(rx_oe),
    .o_ctrl_one(c1), .o_tx_enable(te_o), .o_send_break(sbk_o), .o_tx_bit8(t8_o),
    .o_irq_rx(irq_rx),
    .o_irq_tx(irq_tx), .o_irq_err(irq_err), .o_wake_req(wake));

  asr_far_end u_far (
    .i_clk_sys(clk), .i_rt_tick(rt), .i_go(go), .i_frame(frame), .i_nbits(nb),
    .o_line(line), .o_busy(busy));

  // ----------------------------------------------------------------------
  // Clock, sample tick on every other cycle, and hang guard.
  // ----------------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    rt  <= ~rt;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  // ----------------------------------------------------------------------
  // Bus, frame and compare tasks.
  // ----------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask

  // The answer stands only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic cmp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    if (cmp) chk(rdata, exp);
  endtask

  task automatic send(input logic [8:0] d, input logic nine, input logic stop);
    @(posedge clk);
    frame <= nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
    nb    <= nine ? 4'hB : 4'hA;
    go    <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ASR_OFF_CTRL1, 8'h00, 1);
    rd(`ASR_OFF_STAT1, 8'hC0, 1);
    rd(3'h7, 8'h00, 1);
    wr(`ASR_OFF_CTRL1, 8'h44);
    wr(`ASR_OFF_CTRL2, 8'h3C);
    #1 chk({6'h00, tx_oe, rx_oe}, 8'h02);
    repeat (500) @(posedge clk);
    rd(`ASR_OFF_STAT1, 8'hD0, 1);
    chk({7'h00, irq_rx}, 8'h01);
    rd(`ASR_OFF_DATA, 8'h00, 1);
    rd(`ASR_OFF_STAT1, 8'hC0, 1);
    send(9'h0A5, 1'b0, 1'b1);
    rd(`ASR_OFF_STAT1, 8'hE0, 1);
    chk({7'h00, irq_rx}, 8'h01);
    rd(`ASR_OFF_CTRL3, 8'h80, 1);
    send(9'h03C, 1'b0, 1'b1);
    rd(`ASR_OFF_STAT1, 8'hE8, 1);
    chk({7'h00, irq_err}, 8'h00);
    rd(`ASR_OFF_DATA, 8'hA5, 1);
    rd(`ASR_OFF_STAT1, 8'hC0, 1);
    // A break character with its stop bit missing, then a protected clear.
    wr(`ASR_OFF_CTRL3, 8'h42);
    send(9'h000, 1'b0, 1'b0);
    rd(`ASR_OFF_STAT1, 8'hE2, 1);
    chk({7'h00, irq_err}, 8'h01);
    dbg <= 1'b1;
    rd(`ASR_OFF_DATA, 8'h00, 1);
    rd(`ASR_OFF_STAT1, 8'hE2, 1);
    dbg <= 1'b0;
    rd(`ASR_OFF_DATA, 8'h00, 1);
    rd(`ASR_OFF_STAT1, 8'hC0, 1);
    // Even and odd parity against a character with two ones.
    for (int p = 0; p < 2; p++) begin
      wr(`ASR_OFF_CTRL1, 8'h46 | p[7:0]);
      send(9'h081, 1'b0, 1'b1);
      rd(`ASR_OFF_STAT1, 8'hE0 | p[7:0], 1);
      rd(`ASR_OFF_DATA, 8'h00, 0);
    end
    // Standby with address mark exit.
    wr(`ASR_OFF_CTRL1, 8'h4C);
    wr(`ASR_OFF_CTRL2, 8'h3E);
    send(9'h012, 1'b0, 1'b1);
    rd(`ASR_OFF_STAT1, 8'hC0, 1);
    send(9'h092, 1'b0, 1'b1);
    rd(`ASR_OFF_CTRL2, 8'h3C, 1);
    chk({7'h00, irq_rx}, 8'h01);
    wait_m <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({7'h00, wake}, 8'h01);
    rd(`ASR_OFF_STAT1, 8'h00, 1);
    wait_m <= 1'b0;
    rd(`ASR_OFF_STAT1, 8'hE0, 1);
    rd(`ASR_OFF_DATA, 8'h92, 1);
    // Standby with idle line exit: the waking idle sets no quiet flag.
    wr(`ASR_OFF_CTRL1, 8'h44);
    wr(`ASR_OFF_CTRL2, 8'h3E);
    repeat (400) @(posedge clk);
    rd(`ASR_OFF_CTRL2, 8'h3C, 1);
    rd(`ASR_OFF_STAT1, 8'hC0, 1);
    // Nine-bit character.
    wr(`ASR_OFF_CTRL1, 8'h54);
    send(9'h1AA, 1'b1, 1'b1);
    rd(`ASR_OFF_CTRL3, 8'hC2, 1);
    rd(`ASR_OFF_STAT1, 8'hE0, 1);
    rd(`ASR_OFF_DATA, 8'hAA, 1);
    // Loopback: the frame reaches the receiver only through the transmitter bit.
    wr(`ASR_OFF_CTRL1, 8'hD4);
    lb <= 1'b1;
    send(9'h0C3, 1'b1, 1'b1);
    rd(`ASR_OFF_STAT1, 8'hE0, 1);
    rd(`ASR_OFF_DATA, 8'hC3, 1);
    lb <= 1'b0;
    // Quiet counting after the start bit ends one bit after the stop bit.
    wr(`ASR_OFF_CTRL1, 8'h40);
    send(9'h0FF, 1'b0, 1'b1);
    repeat (40) @(posedge clk);
    rd(`ASR_OFF_STAT1, 8'hF0, 1);
    // With clear enable set, a clear during debug break takes effect.
    dbg <= 1'b1;
    bce <= 1'b1;
    rd(`ASR_OFF_DATA, 8'hFF, 1);
    dbg <= 1'b0;
    bce <= 1'b0;
    rd(`ASR_OFF_STAT1, 8'hC0, 1);
    // Output inversion, then disable.
    wr(`ASR_OFF_CTRL1, 8'h74);
    for (int b = 0; b < 2; b++) begin
      tx_bit <= b[0];
      repeat (3) @(posedge clk);
      #1 chk({7'h00, tx_o}, {7'h00, ~b[0]});
    end
    wr(`ASR_OFF_CTRL2, 8'h3D);
    #1 chk(c1, 8'h74);
    chk({te_o, sbk_o, t8_o, rx_o, 4'h0}, 8'hF0);
    wr(`ASR_OFF_CTRL1, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk({4'h0, tx_o, tx_oe, rx_oe, irq_tx}, 8'h02);
    rd(`ASR_OFF_STAT1, 8'hC0, 1);
    final_report();
  end
endmodule // tb
